// *** hdl/gmcfg_regs.svh ***
/*
 * constants for the joystick and music port configuration banks.
 * assumes a plug-and-play index/data front end that hands over accesses.
 */
// Behaviour
// - each device has a read/write activation register at 30h, reset 00h
// - activation bit 0 clear hides runtime registers; contents kept
// - joystick base high 60h resets 02h, low 61h resets 01h, both writable
// - joystick irq number 70h reads 00h, irq type 71h reads 03h, both fixed
// - both devices: 74h and 75h always read 04h, no dma channel
// - joystick config register at f0h, read/write, reset 00h
// - joystick config bit 4 debounces four buttons, 16 ms quiet time
// - joystick config bit 2 enables pull-ups on four button pins
// - joystick config bit 0 floats outputs while device inactive
// - music base high resets 03h, low resets 30h, low bit 0 reads zero
// - music irq number writable reset 00h; irq type only bit 1 writable
// - music config register at f0h, read/write, reset 00h
// - music config bit 3: 0 legacy mode, 1 enhanced mode
// - legacy mode exposes only data in, data out, status, command
// - enhanced mode exposes the full runtime register set
// - music config bit 2 enables pull-up on the receive pin
// - music config bit 0 floats outputs while device inactive
`ifndef GMCFG_REGS_SVH
`define GMCFG_REGS_SVH

// ------------------------------------------------------------
// logical device numbers
// ------------------------------------------------------------
`define GMCFG_LDN_JOY 8'h0b
`define GMCFG_LDN_MUSIC 8'h0c

// ------------------------------------------------------------
// configuration indices
// ------------------------------------------------------------
`define GMCFG_IDX_ACTIVATE 8'h30
`define GMCFG_IDX_BASE_HIGH 8'h60
`define GMCFG_IDX_BASE_LOW 8'h61
`define GMCFG_IDX_IRQ_NUMBER 8'h70
`define GMCFG_IDX_IRQ_TYPE 8'h71
`define GMCFG_IDX_DMA_0 8'h74
`define GMCFG_IDX_DMA_1 8'h75
`define GMCFG_IDX_CONFIG 8'hf0

// ------------------------------------------------------------
// reset and fixed values
// ------------------------------------------------------------
`define GMCFG_RST_ACTIVATE 8'h00
`define GMCFG_RST_JOY_BASE_HIGH 8'h02
`define GMCFG_RST_JOY_BASE_LOW 8'h01
`define GMCFG_RST_MUSIC_BASE_HIGH 8'h03
`define GMCFG_RST_MUSIC_BASE_LOW 8'h30
`define GMCFG_RST_IRQ_NUMBER 8'h00
`define GMCFG_RST_IRQ_TYPE 8'h03
`define GMCFG_VAL_NO_DMA 8'h04
`define GMCFG_RST_CONFIG 8'h00

// ------------------------------------------------------------
// field positions and writable masks
// ------------------------------------------------------------
`define GMCFG_BIT_ACTIVE 0
`define GMCFG_BIT_FLOAT 0
`define GMCFG_BIT_PULLUP 2
`define GMCFG_BIT_ENHANCED 3
`define GMCFG_BIT_DEBOUNCE 4
`define GMCFG_JOY_CONFIG_MASK 8'h15
`define GMCFG_MUSIC_CONFIG_MASK 8'h0d
`define GMCFG_MUSIC_BASE_LOW_MASK 8'hfe
`define GMCFG_MUSIC_IRQ_TYPE_MASK 8'h02

// ------------------------------------------------------------
// music runtime offsets open in legacy mode
// ------------------------------------------------------------
`define GMCFG_MUSIC_OFS_DATA 4'h0
`define GMCFG_MUSIC_OFS_STATUS 4'h1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GMCFG_DEBOUNCE_MS 16
`define GMCFG_CLOCK_KHZ 250000
`define GMCFG_DEBOUNCE_CYCLES (`GMCFG_DEBOUNCE_MS * `GMCFG_CLOCK_KHZ)

`endif

// *** hdl/gmcfg_pkg.sv ***
/*
 * types for the joystick and music port configuration banks.
 * assumes gmcfg_regs.svh supplies the numeric constants.
 */
package gmcfg_pkg;

    // one configuration access from the index/data front end
    typedef struct packed {
        logic [7:0] ldn;
        logic [7:0] index;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gmcfg_req_t;

    // the register bank of one logical device
    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] irq_number;
        logic [7:0] irq_type;
        logic [7:0] cfg;
    } gmcfg_bank_t;

endpackage

// *** hdl/gmcfg_top.sv ***
/*
 * configuration banks for the joystick and music logical devices, with
 * button debouncing, pull-up and output float control, and runtime gating.
 * assumes the index/data front end presents one access per cycle on req,
 * all inputs synchronous to mclk, and button pins already synchronised.
 */
`timescale 1ns/1ps
`include "gmcfg_regs.svh"

module gmcfg_top #(
    parameter int DEBOUNCE_CYCLES = `GMCFG_DEBOUNCE_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire gmcfg_pkg::gmcfg_req_t req,
    output logic [7:0] rdata,
    input wire logic [3:0] button_pin,
    output logic [3:0] button_level,
    input wire logic joystick_port_selected,
    output logic [3:0] button_pullup,
    input wire logic [3:0] joy_out,
    output logic [3:0] joy_out_pin,
    output logic joy_out_oe_n,
    input wire logic joy_rt_hit,
    output logic joy_rt_accept,
    input wire logic music_port_selected,
    output logic music_receive_pullup,
    input wire logic music_send,
    output logic music_send_pin,
    output logic music_send_oe_n,
    input wire logic music_rt_hit,
    input wire logic [3:0] music_rt_offset,
    output logic music_rt_accept,
    output logic music_enhanced,
    output logic [15:0] joy_base,
    output logic [15:0] music_base,
    output logic [7:0] music_irq_number
);

    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    gmcfg_pkg::gmcfg_bank_t joy;
    gmcfg_pkg::gmcfg_bank_t music;

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] bank_read(
        input gmcfg_pkg::gmcfg_bank_t b,
        input logic [7:0] idx
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `GMCFG_IDX_ACTIVATE: v = b.activate;
            `GMCFG_IDX_BASE_HIGH: v = b.base_high;
            `GMCFG_IDX_BASE_LOW: v = b.base_low;
            `GMCFG_IDX_IRQ_NUMBER: v = b.irq_number;
            `GMCFG_IDX_IRQ_TYPE: v = b.irq_type;
            `GMCFG_IDX_DMA_0: v = `GMCFG_VAL_NO_DMA;
            `GMCFG_IDX_DMA_1: v = `GMCFG_VAL_NO_DMA;
            `GMCFG_IDX_CONFIG: v = b.cfg;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic joy_sel;
    logic music_sel;
    assign joy_sel = (req.ldn == `GMCFG_LDN_JOY);
    assign music_sel = (req.ldn == `GMCFG_LDN_MUSIC);

    // ------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            if (joy_sel) begin
                rdata <= bank_read(joy, req.index);
            end else if (music_sel) begin
                rdata <= bank_read(music, req.index);
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // joystick bank
    // ------------------------------------------------------------
    // irq number and type are constants here: the port has no interrupt
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            joy.activate <= `GMCFG_RST_ACTIVATE;
            joy.base_high <= `GMCFG_RST_JOY_BASE_HIGH;
            joy.base_low <= `GMCFG_RST_JOY_BASE_LOW;
            joy.irq_number <= `GMCFG_RST_IRQ_NUMBER;
            joy.irq_type <= `GMCFG_RST_IRQ_TYPE;
            joy.cfg <= `GMCFG_RST_CONFIG;
        end else if (req.wr && joy_sel) begin
            unique case (req.index)
                `GMCFG_IDX_ACTIVATE: joy.activate <= req.wdata;
                `GMCFG_IDX_BASE_HIGH: joy.base_high <= req.wdata;
                `GMCFG_IDX_BASE_LOW: joy.base_low <= req.wdata;
                `GMCFG_IDX_CONFIG: begin
                    joy.cfg <= req.wdata & `GMCFG_JOY_CONFIG_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // music bank
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            music.activate <= `GMCFG_RST_ACTIVATE;
            music.base_high <= `GMCFG_RST_MUSIC_BASE_HIGH;
            music.base_low <= `GMCFG_RST_MUSIC_BASE_LOW;
            music.irq_number <= `GMCFG_RST_IRQ_NUMBER;
            music.irq_type <= `GMCFG_RST_IRQ_TYPE;
            music.cfg <= `GMCFG_RST_CONFIG;
        end else if (req.wr && music_sel) begin
            unique case (req.index)
                `GMCFG_IDX_ACTIVATE: music.activate <= req.wdata;
                `GMCFG_IDX_BASE_HIGH: music.base_high <= req.wdata;
                `GMCFG_IDX_BASE_LOW: begin
                    music.base_low <= req.wdata
                        & `GMCFG_MUSIC_BASE_LOW_MASK;
                end
                `GMCFG_IDX_IRQ_NUMBER: music.irq_number <= req.wdata;
                `GMCFG_IDX_IRQ_TYPE: begin
                    music.irq_type <= (req.wdata
                        & `GMCFG_MUSIC_IRQ_TYPE_MASK)
                        | (`GMCFG_RST_IRQ_TYPE
                        & ~`GMCFG_MUSIC_IRQ_TYPE_MASK);
                end
                `GMCFG_IDX_CONFIG: begin
                    music.cfg <= req.wdata
                        & `GMCFG_MUSIC_CONFIG_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // runtime gating
    // ------------------------------------------------------------
    logic joy_active;
    logic music_active;
    logic music_legacy_ofs;
    assign joy_active = joy.activate[`GMCFG_BIT_ACTIVE];
    assign music_active = music.activate[`GMCFG_BIT_ACTIVE];
    assign music_enhanced = music.cfg[`GMCFG_BIT_ENHANCED];
    assign music_legacy_ofs = (music_rt_offset == `GMCFG_MUSIC_OFS_DATA)
        || (music_rt_offset == `GMCFG_MUSIC_OFS_STATUS);
    // deactivation only blocks access; runtime contents stay put
    assign joy_rt_accept = joy_rt_hit && joy_active;
    assign music_rt_accept = music_rt_hit && music_active
        && (music_enhanced || music_legacy_ofs);
    assign joy_base = {joy.base_high, joy.base_low};
    assign music_base = {music.base_high, music.base_low};
    assign music_irq_number = music.irq_number;

    // ------------------------------------------------------------
    // pins: pull-ups and output float
    // ------------------------------------------------------------
    assign button_pullup = {4{joystick_port_selected
        && joy.cfg[`GMCFG_BIT_PULLUP]}};
    assign music_receive_pullup = music_port_selected
        && music.cfg[`GMCFG_BIT_PULLUP];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            joy_out_pin <= 4'h0;
            joy_out_oe_n <= 1'b0;
        end else begin
            joy_out_pin <= joy_out;
            joy_out_oe_n <= joy.cfg[`GMCFG_BIT_FLOAT] && !joy_active;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            music_send_pin <= 1'b1;
            music_send_oe_n <= 1'b0;
        end else begin
            music_send_pin <= music_send;
            music_send_oe_n <= music.cfg[`GMCFG_BIT_FLOAT]
                && !music_active;
        end
    end

    // ------------------------------------------------------------
    // button debouncers
    // ------------------------------------------------------------
    // a transition restarts the quiet-time count, so chatter never passes
    logic debounce_on;
    assign debounce_on = joy.cfg[`GMCFG_BIT_DEBOUNCE];

    for (genvar i = 0; i < 4; i++) begin : g_btn
        logic last;
        logic [CW-1:0] quiet;
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                last <= 1'b1;
                quiet <= '0;
                button_level[i] <= 1'b1;
            end else begin
                last <= button_pin[i];
                if (!debounce_on) begin
                    quiet <= '0;
                    button_level[i] <= button_pin[i];
                end else if (button_pin[i] != last) begin
                    quiet <= '0;
                end else if (quiet == CW'(DEBOUNCE_CYCLES - 1)) begin
                    button_level[i] <= last;
                end else begin
                    quiet <= quiet + 1'b1;
                end
            end
        end
    end

endmodule // gmcfg_top

// *** testbench/gmcfg_properties.sv ***
/* checker for gmcfg_top: gating, pull-ups, float, buttons, read data.
   assumes it is bound to gmcfg_top and shares its debounce parameter. */
`timescale 1ns/1ps
`include "gmcfg_regs.svh"
module gmcfg_checker #(
    parameter int DEBOUNCE_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire gmcfg_pkg::gmcfg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic [3:0] button_pin,
    input wire logic [3:0] button_level,
    input wire logic joystick_port_selected,
    input wire logic [3:0] button_pullup,
    input wire logic joy_out_oe_n,
    input wire logic [3:0] joy_out,
    input wire logic [3:0] joy_out_pin,
    input wire logic joy_rt_hit,
    input wire logic joy_rt_accept,
    input wire logic music_port_selected,
    input wire logic music_receive_pullup,
    input wire logic music_send_oe_n,
    input wire logic music_send,
    input wire logic music_send_pin,
    input wire logic music_rt_hit,
    input wire logic [3:0] music_rt_offset,
    input wire logic music_rt_accept,
    input wire logic music_enhanced
);
    // ----------------------------------------
    // shadow of the bits the outputs hang on
    // ----------------------------------------
    logic joy_act, mus_act;
    logic [7:0] joy_cfg, mus_cfg;
    logic [3:0] last_pin;
    logic [31:0] quiet [4];
    logic [3:0] settled;
    wire wj = req.wr && req.ldn == `GMCFG_LDN_JOY;
    wire wm = req.wr && req.ldn == `GMCFG_LDN_MUSIC;
    wire at_act = req.index == `GMCFG_IDX_ACTIVATE;
    wire at_cfg = req.index == `GMCFG_IDX_CONFIG;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            joy_act <= 1'b0;
            mus_act <= 1'b0;
            joy_cfg <= 8'h00;
            mus_cfg <= 8'h00;
        end else begin
            if (wj && at_act) joy_act <= req.wdata[0];
            if (wm && at_act) mus_act <= req.wdata[0];
            if (wj && at_cfg) joy_cfg <= req.wdata;
            if (wm && at_cfg) mus_cfg <= req.wdata;
        end
    end
    // quiet time per button: one bouncing pin must not hold back the rest
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_pin <= 4'hf;
            for (int i = 0; i < 4; i++) quiet[i] <= 32'h0;
        end else begin
            last_pin <= button_pin;
            for (int i = 0; i < 4; i++) begin
                quiet[i] <= (button_pin[i] != last_pin[i]) ? 32'h0
                    : quiet[i] + 32'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            settled[i] = quiet[i] >= 32'(DEBOUNCE_CYCLES - 2);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_rdata_hold: assert property (!req.rd |=> $stable(rdata))
        else $error("read data moved without a read");
    a_joy_gate: assert property (joy_rt_accept == (joy_rt_hit && joy_act))
        else $error("joystick runtime gating wrong");
    a_music_gate: assert property (music_rt_accept == (music_rt_hit
        && mus_act && (mus_cfg[3] || music_rt_offset <= 4'h1)))
        else $error("music runtime gating wrong");
    a_mode_select: assert property (music_enhanced == mus_cfg[3])
        else $error("music mode flag wrong");
    a_joy_pullup: assert property (button_pullup ==
        {4{joystick_port_selected && joy_cfg[2]}})
        else $error("button pull-up wrong");
    a_music_pullup: assert property (music_receive_pullup ==
        (music_port_selected && mus_cfg[2]))
        else $error("receive pull-up wrong");
    a_joy_float: assert property (joy_out_oe_n ==
        $past(joy_cfg[0] && !joy_act))
        else $error("joystick output float wrong");
    a_music_float: assert property (music_send_oe_n ==
        $past(mus_cfg[0] && !mus_act))
        else $error("music output float wrong");
    a_button_pass: assert property (!joy_cfg[4] |=>
        button_level == $past(button_pin))
        else $error("undebounced button not passed");
    a_button_quiet: assert property (joy_cfg[4] && $past(joy_cfg[4])
        |-> ((button_level ^ $past(button_level)) & ~settled) == 4'h0)
        else $error("debounced button changed too early");
    a_joy_pin_data: assert property ($past(rstn) |->
        joy_out_pin == $past(joy_out))
        else $error("joystick pin data wrong");
    a_music_pin_data: assert property ($past(rstn) |->
        music_send_pin == $past(music_send))
        else $error("music pin data wrong");
endmodule // gmcfg_checker

bind gmcfg_top gmcfg_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.*);

// *** testbench/tb_game_and_midi_port_config.sv ***
/* testbench for gmcfg_top: register banks, masks, float, debounce.
   assumes the checker file is compiled with it and bound in. */
`timescale 1ns/1ps
`include "gmcfg_regs.svh"
module tb_game_and_midi_port_config;
    localparam int DB = 8;
    localparam logic [7:0] J = `GMCFG_LDN_JOY;
    localparam logic [7:0] M = `GMCFG_LDN_MUSIC;
    localparam logic [7:0] IDX [8] = '{8'h30, 8'h60, 8'h61, 8'h70,
        8'h71, 8'h74, 8'h75, 8'hf0};
    localparam logic [7:0] RJ [8] = '{8'h00, 8'h02, 8'h01, 8'h00,
        8'h03, 8'h04, 8'h04, 8'h00};
    localparam logic [7:0] RM [8] = '{8'h00, 8'h03, 8'h30, 8'h00,
        8'h03, 8'h04, 8'h04, 8'h00};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    gmcfg_pkg::gmcfg_req_t req = '0;
    logic [7:0] rdata, d, music_irq_number;
    logic [15:0] joy_base, music_base;
    logic [3:0] button_pin = 4'hf, button_level, joy_out = 4'h0;
    logic [3:0] music_rt_offset = 4'h0;
    logic joystick_port_selected = 1'b0, joy_rt_hit = 1'b0;
    logic music_port_selected = 1'b0, music_send = 1'b0;
    logic music_rt_hit = 1'b0, joy_out_oe_n, music_send_oe_n;
    logic taken = 1'b0, btn_free = 1'b1;
    logic [7:0] expq [$];
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    gmcfg_top #(.DEBOUNCE_CYCLES(DB)) uut (.mclk, .rstn, .req, .rdata,
        .button_pin, .button_level, .joystick_port_selected,
        .button_pullup(), .joy_out, .joy_out_pin(), .joy_out_oe_n,
        .joy_rt_hit, .joy_rt_accept(), .music_port_selected,
        .music_receive_pullup(), .music_send, .music_send_pin(),
        .music_send_oe_n, .music_rt_hit, .music_rt_offset,
        .music_rt_accept(), .music_enhanced(), .joy_base,
        .music_base, .music_irq_number);

    always #2 mclk = ~mclk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // request held for exactly one edge; no clearing, so back to back is safe
    task automatic acc(input logic [7:0] l, i, v, input logic w, r);
        req = '{l, i, v, w, r};
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] l, i, e);
        expq.push_back(e);
        acc(l, i, 8'h00, 1'b0, 1'b1);
    endtask
    function automatic logic [7:0] expv(input logic m, input int k,
        input logic [7:0] v);
        case (k)
            0, 1: return v;
            2: return m ? v & 8'hfe : v;
            3: return m ? v : 8'h00;
            4: return m ? 8'h01 | (v & 8'h02) : 8'h03;
            7: return m ? v & 8'h0d : v & 8'h15;
            default: return 8'h04;
        endcase
    endfunction

    always @(posedge mclk) taken <= req.rd;
    always @(negedge mclk) begin
        if (taken && expq.size() > 0) begin
            check(rdata, expq.pop_front());
        end
    end
    // random pins and runtime hits keep the gating assertions busy
    always @(posedge mclk) begin
        #1;
        {joystick_port_selected, joy_rt_hit, music_port_selected, music_send,
            music_rt_hit, music_rt_offset, joy_out} = 13'($urandom());
        if (btn_free) button_pin = 4'($urandom());
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        void'($urandom(31));
        repeat (6) @(posedge mclk);
        #1;
        rstn = 1'b1;
        check(joy_base[15:8], 8'h02);
        check(joy_base[7:0], 8'h01);
        check(music_base[15:8], 8'h03);
        check(music_base[7:0], 8'h30);
        check(music_irq_number, 8'h00);
        for (int k = 0; k < 8; k++) begin
            rd(J, IDX[k], RJ[k]);
            rd(M, IDX[k], RM[k]);
        end
        rd(8'h0d, 8'h30, 8'h00);
        rd(J, 8'h31, 8'h00);
        for (int n = 0; n < 4; n++) begin
            d = 8'($urandom());
            for (int k = 0; k < 8; k++) begin
                acc(J, IDX[k], d, 1'b1, 1'b0);
                acc(M, IDX[k], d, 1'b1, 1'b0);
            end
            for (int k = 0; k < 8; k++) begin
                rd(J, IDX[k], expv(1'b0, k, d));
                rd(M, IDX[k], expv(1'b1, k, d));
            end
            check(joy_base[15:8], d);
            check(joy_base[7:0], d);
            check(music_base[7:0], d & 8'hfe);
            check(music_irq_number, d);
        end
        acc(J, 8'h60, 8'h5a, 1'b1, 1'b0);
        expq.push_back(8'h5a);
        acc(J, 8'h60, 8'ha5, 1'b1, 1'b1);
        rd(J, 8'h60, 8'ha5);
        acc(J, 8'hf0, 8'h01, 1'b1, 1'b0);
        acc(J, 8'h30, 8'h00, 1'b1, 1'b0);
        acc(M, 8'hf0, 8'h01, 1'b1, 1'b0);
        acc(M, 8'h30, 8'h00, 1'b1, 1'b0);
        acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        check({7'h0, joy_out_oe_n}, 8'h01);
        check({7'h0, music_send_oe_n}, 8'h01);
        acc(M, 8'h30, 8'h01, 1'b1, 1'b0);
        acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        check({7'h0, music_send_oe_n}, 8'h00);
        // bounce shorter than the quiet time must not get through
        btn_free = 1'b0;
        button_pin = 4'hf;
        repeat (12) acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        acc(J, 8'hf0, 8'h10, 1'b1, 1'b0);
        acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        button_pin = 4'h0;
        repeat (3) acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        button_pin = 4'h5;
        // one edge before the steady bits have been quiet long enough
        repeat (DB - 3) acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        check({4'h0, button_level}, 8'h0f);
        repeat (6) acc(J, 8'h00, 8'h00, 1'b0, 1'b0);
        check({4'h0, button_level}, 8'h05);
        close_out();
    end
endmodule // tb_game_and_midi_port_config
